// file: bench/quadrature_status_flags_chk.sv
// Concurrent checks for the encoder status block: waits, status reads, irq.
// Assumes it is bound to the top module and sees nothing but its ports.
`timescale 1ns/1ns
`default_nettype none
module quadrature_status_flags_chk (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [31:0] position_count,
    input wire logic        position_overflow_evt,
    input wire logic        velocity_overflow_evt,
    input wire logic        homing_reinit_evt,
    input wire logic        home_evt,
    input wire logic        index_evt,
    input wire logic [2:0]  position_init_mode,
    input wire logic        irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0]  rs_q;  // Reset copy, lifts two edges late like the design
    logic [6:0]  f_q;   // Expected flags, index at bit 0
    logic [6:0]  en_q;  // Expected enables
    logic [6:0]  mk_q;  // Expected mask
    logic [31:0] ge_q;  // Expected GE compare value
    logic [31:0] le_q;  // Expected LE compare value
    logic [31:0] st_q;  // Status word as it stood one cycle back
    logic        irq_q; // Expected irq level
    logic [31:0] m;     // Byte lane mask of the current write
    logic [4:0]  ev;    // Events, homing only in the two homing modes
    logic [4:0]  cl;    // Flags cleared by a zero write
    logic        wr;    // Write completes this cycle
    logic        ws;    // Status write completes this cycle
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    assign m  = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign wr = write && !waitrequest;
    assign ws = wr && address == 5'h00;
    assign ev = {position_overflow_evt,
                 homing_reinit_evt && (position_init_mode == 3'h3 || position_init_mode == 3'h4),
                 velocity_overflow_evt, home_evt, index_evt};
    // Only a zero in an enabled lane clears; ones are ignored
    always_comb begin
        for (int i = 0; i < 5; i++) cl[i] = ws && m[2*i+1] && !writedata[2*i+1];
    end
    ////////////////////////////////////////////////////////////////////////
    // Mirror the internal two-flop release so the shadow starts in step
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) rs_q <= 2'h0;
        else rs_q <= {rs_q[0], 1'b1};
    end
    // Shadow registers; a set in the same cycle as a clear wins
    always_ff @(posedge clock or negedge rs_q[1]) begin
        if (!rs_q[1]) begin
            f_q <= 7'h00;
            en_q <= 7'h00;
            mk_q <= 7'h7F;
            ge_q <= 32'h0;
            le_q <= 32'h0;
            st_q <= 32'h0;
            irq_q <= 1'b0;
        end else begin
            f_q[6] <= $signed(position_count) >= $signed(ge_q);
            f_q[5] <= $signed(position_count) <= $signed(le_q);
            f_q[4:0] <= ev | (f_q[4:0] & ~cl);
            for (int i = 0; i < 7; i++) begin
                if (ws && m[2*i]) en_q[i] <= writedata[2*i];
                st_q[2*i+1] <= f_q[i];
                st_q[2*i] <= en_q[i];
            end
            if (wr && address == 5'h04) ge_q <= (ge_q & ~m) | (writedata & m);
            if (wr && address == 5'h08) le_q <= (le_q & ~m) | (writedata & m);
            if (wr && address == 5'h14 && byteenable[0]) mk_q <= writedata[6:0];
            irq_q <= |(f_q & en_q & mk_q);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_wait;
        (read || write) && waitrequest;
    endsequence
    sequence s_stat;
        read && !waitrequest && address == 5'h00;
    endsequence
    a_first_wait: assert property (($rose(read) || $rose(write)) |-> waitrequest)
        else $error("request answered with no wait state");
    a_one_wait: assert property (s_wait |=> !waitrequest)
        else $error("more than one wait state");
    a_unmapped_zero: assert property (read && !waitrequest && address >= 5'h18 |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    a_ge_live: assert property (s_stat |-> readdata[13] == st_q[13])
        else $error("GE compare flag wrong");
    a_le_live: assert property (s_stat |-> readdata[11] == st_q[11])
        else $error("LE compare flag wrong");
    a_event_flags: assert property (s_stat |-> (readdata & 32'h22A) == (st_q & 32'h22A))
        else $error("sticky event flag wrong");
    a_homing_flag: assert property (s_stat |-> readdata[7] == st_q[7])
        else $error("homing flag wrong");
    a_enable_bits: assert property (s_stat |-> (readdata & 32'h1555) == (st_q & 32'h1555))
        else $error("enable bit wrong");
    a_upper_zero: assert property (s_stat |-> readdata[31:14] == 18'h0)
        else $error("status upper bits not zero");
    a_irq_level: assert property (irq == irq_q)
        else $error("irq level wrong");
    a_irq_reset: assert property (disable iff (1'b0) !resetn |-> !irq)
        else $error("irq high in reset");
endmodule : quadrature_status_flags_chk
bind quadrature_status_flags quadrature_status_flags_chk quadrature_status_flags_chk_inst (
    .clock, .resetn, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .position_count, .position_overflow_evt, .velocity_overflow_evt,
    .homing_reinit_evt, .home_evt, .index_evt, .position_init_mode, .irq);
`default_nettype wire

// file: bench/quadrature_status_flags_tb.sv
// Self-checking bench for the encoder status block over Avalon-MM.
// Assumes the package, the design and the bound checker compile first.
`timescale 1ns/1ns
`default_nettype none
module quadrature_status_flags_tb;
    logic        clock = 1'b0;
    logic        resetn = 1'b1;
    logic [4:0]  address = 5'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [31:0] position_count = 32'h0;
    logic [4:0]  ev = 5'h00;  // Index, home, velocity, homing, position
    logic [2:0]  position_init_mode;
    logic        irq;
    logic [31:0] q;           // Last read data
    int          err_total = 0;
    int          n_checks = 0;
    // Signed edge cases for the compares: GE is 100, LE is -5
    logic [31:0] pv [7] = '{32'h64, 32'h63, 32'hFFFF_FFFB, 32'hFFFF_FFFA,
                            32'h7FFF_FFFF, 32'h8000_0000, 32'h32};
    logic [31:0] sv [7] = '{32'h2000, 32'h0, 32'h800, 32'h800, 32'h2000, 32'h800, 32'h0};
    always #4 clock = ~clock;
    quadrature_status_flags quadrature_status_flags_inst (
        .clock, .resetn, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .position_count, .position_overflow_evt(ev[4]),
        .velocity_overflow_evt(ev[2]), .homing_reinit_evt(ev[3]), .home_evt(ev[1]),
        .index_evt(ev[0]), .position_init_mode, .irq);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // One transfer, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= d;
        byteenable <= b;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 64);
        if (n >= 64) chk("waitrequest", 32'h0, 32'h1);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic rc(input string s, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(s, e, q);
    endtask : rc
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask : wr
    // One-cycle event pulse on input k
    task automatic pulse(input int k);
        @(posedge clock);
        ev <= 5'h01 << k;
        @(posedge clock);
        ev <= 5'h00;
    endtask : pulse
    // Irq is registered, so let it settle before looking
    task automatic irq_is(input logic e);
        repeat (3) @(negedge clock);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : irq_is
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        final_report;
    end
    initial begin
        // A real falling edge at time zero, so the async resets take hold at once
        resetn <= 1'b0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        // Reset values; count 0 sits on both compares
        rc("status", 5'h00, 32'h2800);
        rc("ge", 5'h04, 32'h0);
        rc("le", 5'h08, 32'h0);
        rc("mode", 5'h0C, 32'h0);
        rc("mask", 5'h14, 32'h7F);
        rc("unmapped", 5'h18, 32'h0);
        irq_is(1'b0);
        $display("reset test done");
        // Each sticky event alone, then cleared by a zero write
        wr(5'h0C, 32'h3);
        for (int k = 0; k < 5; k++) begin
            pulse(k);
            rc("status", 5'h00, 32'h2800 | (32'h2 << (2 * k)));
            wr(5'h00, 32'h0);
        end
        pulse(0);
        wr(5'h00, 32'h2AA);
        rc("status", 5'h00, 32'h2802);
        wr(5'h00, 32'h0);
        rc("status", 5'h00, 32'h2800);
        for (int i = 0; i < 8; i++) begin
            wr(5'h0C, 32'(i));
            rc("mode", 5'h0C, 32'(i));
            chk("mode pin", 32'(i), {29'h0, position_init_mode});
            pulse(3);
            rc("status", 5'h00, (i == 3 || i == 4) ? 32'h2880 : 32'h2800);
            wr(5'h00, 32'h0);
        end
        $display("event test done");
        // Compares, with a two-lane write to GE
        bus(1'b1, 5'h04, 32'hAAAA_0064, 4'h3);
        rc("ge", 5'h04, 32'h64);
        wr(5'h08, 32'hFFFF_FFFB);
        for (int i = 0; i < 7; i++) begin
            position_count <= pv[i];
            rc("status", 5'h00, sv[i]);
        end
        $display("compare test done");
        // Enables, mask, event log and irq
        wr(5'h00, 32'h1555);
        rc("status", 5'h00, 32'h1555);
        irq_is(1'b0);
        bus(1'b0, 5'h10, 32'h0, 4'hF);
        pulse(0);
        irq_is(1'b1);
        wr(5'h14, 32'h0);
        irq_is(1'b0);
        wr(5'h14, 32'h7F);
        irq_is(1'b1);
        rc("log", 5'h10, 32'h1);
        rc("log", 5'h10, 32'h0);
        wr(5'h00, 32'h1555);
        irq_is(1'b0);
        wr(5'h18, 32'hFFFF_FFFF);
        rc("unmapped", 5'h18, 32'h0);
        rc("status", 5'h00, 32'h1555);
        position_count <= 32'h64;
        irq_is(1'b1);
        $display("irq test done");
        final_report;
    end
endmodule : quadrature_status_flags_tb
`default_nettype wire

// file: rtl/quadrature_status_flags.sv
// Status flags and interrupt enables of a quadrature encoder interface.
// Assumes events arrive as one-cycle pulses synchronous to clock and that
// the position count is a signed value from the counter in the same domain.
`timescale 1ns/1ns
`default_nettype none

module quadrature_status_flags (
    input  wire  logic        clock,                  // 125 MHz
    input  wire  logic        resetn,                 // Async, active low
    // Avalon-MM slave
    input  wire  logic [4:0]  address,                // Byte address
    input  wire  logic        read,                   // Read request
    input  wire  logic        write,                  // Write request
    input  wire  logic [31:0] writedata,              // Write data
    input  wire  logic [3:0]  byteenable,             // Byte lanes
    output logic [31:0]       readdata,               // Read data
    output logic              waitrequest,            // Stall
    // Counter side
    input  wire  logic [31:0] position_count,         // Signed position
    input  wire  logic        position_overflow_evt,  // Pulse
    input  wire  logic        velocity_overflow_evt,  // Pulse
    input  wire  logic        homing_reinit_evt,      // Pulse
    input  wire  logic        home_evt,               // Pulse
    input  wire  logic        index_evt,              // Pulse
    // Mode and interrupt
    output logic [2:0]        position_init_mode,     // To the counter
    output logic              irq                     // Level interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Merge write data into a register under the byte enables
    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // Interleave flags (odd bits) and enables (even bits)
    function automatic logic [31:0] pack(
        input logic [6:0] f,
        input logic [6:0] e
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; i < 7; i++) begin
            r[2*i+1] = f[i];
            r[2*i]   = e[i];
        end
        return r;
    endfunction : pack

    ////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta_q;   // First synchroniser stage
    logic rst_n_q;      // Released reset used everywhere

    // Assert at once, release after two edges
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake

    logic        ack_q;     // High in the cycle the access completes
    logic        acc_wr;    // Write takes effect this edge
    logic        acc_rd;    // Read completes this edge
    logic [31:0] rd_mux;    // Read data selected by address

    // One wait state: request seen, then completed on the next edge
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read | write) & ~ack_q;
        end
    end

    // Stall until the acknowledge cycle
    assign waitrequest = (read | write) & ~ack_q;
    assign acc_wr      = write & ack_q;
    assign acc_rd      = read & ack_q;

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    logic [31:0] ge_cmp_q;   // ge_compare_value
    logic [31:0] le_cmp_q;   // le_compare_value
    logic [2:0]  mode_q;     // position_init_mode
    logic [6:0]  en_q;       // Per-flag interrupt enables
    logic [6:0]  mask_q;     // Mask on the interrupt output
    logic [31:0] mode_word;  // Mode register merged with write
    logic [31:0] mask_word;  // Mask register merged with write
    logic [31:0] stat_word;  // Status register merged with write
    logic [6:0]  flags_q;    // Flags in index order
    logic [6:0]  flags_d;    // Next flags

    assign mode_word = merge({29'h0, mode_q}, writedata, byteenable);
    assign mask_word = merge({25'h0, mask_q}, writedata, byteenable);
    assign stat_word = merge(pack(flags_q, en_q), writedata, byteenable);

    // Compare values
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ge_cmp_q <= quadrature_status_pkg::RST_CMP;
            le_cmp_q <= quadrature_status_pkg::RST_CMP;
        end else if (acc_wr && address == quadrature_status_pkg::OFS_GE_CMP) begin
            ge_cmp_q <= merge(ge_cmp_q, writedata, byteenable);
        end else if (acc_wr && address == quadrature_status_pkg::OFS_LE_CMP) begin
            le_cmp_q <= merge(le_cmp_q, writedata, byteenable);
        end
    end

    // Position init mode and interrupt mask
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= quadrature_status_pkg::RST_MODE;
            mask_q <= quadrature_status_pkg::RST_MASK;
        end else if (acc_wr && address == quadrature_status_pkg::OFS_CTRL) begin
            mode_q <= mode_word[2:0];
        end else if (acc_wr && address == quadrature_status_pkg::OFS_EV_MASK) begin
            mask_q <= mask_word[6:0];
        end
    end

    // Enables sit in the even bits of the status register
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            en_q <= quadrature_status_pkg::RST_EN;
        end else if (acc_wr && address == quadrature_status_pkg::OFS_STATUS) begin
            for (int i = 0; i < 7; i++) begin
                en_q[i] <= stat_word[2*i];
            end
        end
    end

    assign position_init_mode = mode_q;

    ////////////////////////////////////////////////////////////////////////
    // Flag sources

    logic       ge_hit;      // Count at or above GE compare
    logic       le_hit;      // Count at or below LE compare
    logic       homing_ok;   // Mode reports homing completion
    logic [6:0] set_vec;     // Hardware set per flag
    logic [6:0] clr_vec;     // Software clear per flag

    // Signed compares: the counter runs both ways through zero
    assign ge_hit = $signed(position_count) >= $signed(ge_cmp_q);
    assign le_hit = $signed(position_count) <= $signed(le_cmp_q);

    // Homing flag only meaningful in the two homing modes
    assign homing_ok = (mode_q == quadrature_status_pkg::MODE_HOME_A)
                     | (mode_q == quadrature_status_pkg::MODE_HOME_B);

    // Collect hardware sets in flag order
    always_comb begin
        set_vec = 7'h00;
        set_vec[quadrature_status_pkg::IDX_POSOV]  = position_overflow_evt;
        set_vec[quadrature_status_pkg::IDX_HOMING] = homing_reinit_evt
                                                   & homing_ok;
        set_vec[quadrature_status_pkg::IDX_VELOV]  = velocity_overflow_evt;
        set_vec[quadrature_status_pkg::IDX_HOME]   = home_evt;
        set_vec[quadrature_status_pkg::IDX_INDEX]  = index_evt;
    end

    // A zero written to a flag bit clears it; a one does nothing
    always_comb begin
        clr_vec = 7'h00;
        if (acc_wr && address == quadrature_status_pkg::OFS_STATUS) begin
            for (int i = 0; i < 7; i++) begin
                clr_vec[i] = ~stat_word[2*i+1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags

    // Flag state is declared beside the status write merge, which reads it

    // Event flags are sticky; set wins over a clear in the same cycle
    always_comb begin
        flags_d = flags_q;
        for (int i = 0; i < 5; i++) begin
            if (set_vec[i]) begin
                flags_d[i] = 1'b1;
            end else if (clr_vec[i]) begin
                flags_d[i] = 1'b0;
            end
        end
        // Compare flags follow the comparison, so a clear only holds
        // once the count has left the window
        flags_d[quadrature_status_pkg::IDX_GE] = ge_hit;
        flags_d[quadrature_status_pkg::IDX_LE] = le_hit;
    end

    // Flags start clear
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flags_q <= quadrature_status_pkg::RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event log and interrupt

    logic [6:0] ev_q;      // Sticky log of flag rises
    logic [6:0] rise;      // Flags rising this cycle
    logic       ev_rdclr;  // Event log read completes

    assign rise     = flags_d & ~flags_q;
    assign ev_rdclr = acc_rd && address == quadrature_status_pkg::OFS_EVENTS;

    // Read clears only the bits it returned, so a rise during the wait
    // state or in the completing cycle is kept for the next read
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ev_q <= 7'h00;
        end else if (ev_rdclr) begin
            ev_q <= (ev_q & ~readdata[6:0]) | rise;
        end else begin
            ev_q <= ev_q | rise;
        end
    end

    // Level request while any enabled, unmasked flag stands
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags_q & en_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    // Address decode; unmapped addresses read zero
    always_comb begin
        if (address == quadrature_status_pkg::OFS_STATUS) begin
            rd_mux = pack(flags_q, en_q);
        end else if (address == quadrature_status_pkg::OFS_GE_CMP) begin
            rd_mux = ge_cmp_q;
        end else if (address == quadrature_status_pkg::OFS_LE_CMP) begin
            rd_mux = le_cmp_q;
        end else if (address == quadrature_status_pkg::OFS_CTRL) begin
            rd_mux = {29'h0, mode_q};
        end else if (address == quadrature_status_pkg::OFS_EVENTS) begin
            rd_mux = {25'h0, ev_q};
        end else if (address == quadrature_status_pkg::OFS_EV_MASK) begin
            rd_mux = {25'h0, mask_q};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // Capture in the stall cycle so data stands at the completing edge
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack_q) begin
            readdata <= rd_mux;
        end
    end

endmodule : quadrature_status_flags

`default_nettype wire

// file: rtl/quadrature_status_pkg.sv
// Constants for the quadrature encoder status and interrupt block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
package quadrature_status_pkg;

    // Data path widths
    localparam int unsigned POS_W   = 32;  // Position counter and compare width
    localparam int unsigned NFLAG   = 7;   // Number of flag/enable pairs
    localparam int unsigned ADDR_W  = 5;   // Byte address width of the slave
    localparam int unsigned DATA_W  = 32;  // Bus data width
    localparam int unsigned MODE_W  = 3;   // Position init mode field width

    // Register byte offsets
    localparam logic [4:0] OFS_STATUS  = 5'h00; // encoder_status_and_irq_enable
    localparam logic [4:0] OFS_GE_CMP  = 5'h04; // ge_compare_value
    localparam logic [4:0] OFS_LE_CMP  = 5'h08; // le_compare_value
    localparam logic [4:0] OFS_CTRL    = 5'h0C; // position_init_mode
    localparam logic [4:0] OFS_EVENTS  = 5'h10; // Sticky event log, read clears
    localparam logic [4:0] OFS_EV_MASK = 5'h14; // Interrupt mask

    // Flag index; status bit of flag i is 2*i+1, its enable is 2*i
    localparam int unsigned IDX_GE     = 6;   // Bits 13 / 12
    localparam int unsigned IDX_LE     = 5;   // Bits 11 / 10
    localparam int unsigned IDX_POSOV  = 4;   // Bits 9 / 8
    localparam int unsigned IDX_HOMING = 3;   // Bits 7 / 6
    localparam int unsigned IDX_VELOV  = 2;   // Bits 5 / 4
    localparam int unsigned IDX_HOME   = 1;   // Bits 3 / 2
    localparam int unsigned IDX_INDEX  = 0;   // Bits 1 / 0

    // Init modes in which homing completion is reported
    localparam logic [2:0] MODE_HOME_A = 3'h3;
    localparam logic [2:0] MODE_HOME_B = 3'h4;

    // Reset values
    localparam logic [6:0]  RST_FLAGS = 7'h00;
    localparam logic [6:0]  RST_EN    = 7'h00;
    localparam logic [6:0]  RST_MASK  = 7'h7F;
    localparam logic [31:0] RST_CMP   = 32'h0000_0000;
    localparam logic [2:0]  RST_MODE  = 3'h0;

endpackage : quadrature_status_pkg
